// ==== design/ioc_osc_ctrl.v ====
// internal oscillator control: high-frequency enable, ready, suspend
// and divider, multiplier compatibility register, low-frequency
// divider, tuning, ready and the timer capture hook.
// assumes single-cycle sfr read/write strobes on clk_sys, analog
// status pins that are asynchronous, and timers on clk_sys.
//
// Operation
// - hf control bit 7 enables the hf oscillator, read/write, resets to 1.
// - hf control bit 6 reads 1 while hf oscillator runs at programmed rate.
// - writing 1 to hf control bit 5 suspends; a wake event restarts.
// - wake on port 0 match, port 1 match, timer 3 overflow, usb resume.
// - bits 4 to 2 of hf control and multiplier register read zero.
// - hf divider divides by 4 then by 8, 4, 2 or 1; resets 00.
// - multiplier register is read-only, reports present, enabled, locked multiplier.
// - multiplier enable bit 7 always reads 1.
// - multiplier lock bit 5 and initialize bit 6 always read 1.
// - multiplier input select bits 1 to 0 always read 00.
// - lf oscillator output passes through a divide by 1, 2, 4 or 8.
// - lf divider code 00 is /8, 01 /4, 10 /2, 11 /1; resets 00.
// - four-bit lf fine-tune field trims the oscillator frequency.
// - lf ready clears only on reset or a change of lf divider.
// - in capture mode timer 2 takes falling, timer 3 rising lf edges.
// - on capture the timer count is copied into its reload pair.
`timescale 1ns/100ps
`include "ioc_osc_defs.vh"

module ioc_osc_ctrl #(
   parameter TIMER_WIDTH = 16
) (
   // clock and reset
   input wire clk_sys,
   input wire arst_n,
   // sfr bus
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // analog status pins
   input wire hf_osc_stable,
   input wire lf_osc_stable,
   input wire lf_osc_raw,
   // wake events
   input wire port0_match,
   input wire port1_match,
   input wire timer3_overflow,
   input wire usb_resume,
   // timer capture hook
   input wire tmr2_lf_capture_mode,
   input wire tmr3_lf_capture_mode,
   input wire [TIMER_WIDTH-1:0] tmr2_timer_count,
   input wire [TIMER_WIDTH-1:0] tmr3_timer_count,
   output wire [TIMER_WIDTH-1:0] tmr2_timer_reload,
   output wire tmr2_reload_load,
   output wire [TIMER_WIDTH-1:0] tmr3_timer_reload,
   output wire tmr3_reload_load,
   // oscillator controls
   output reg hf_osc_enable,
   output reg hf_osc_suspend,
   output reg [1:0] hf_divider_sel,
   output reg hf_clk_en,
   output reg wake_pulse,
   output reg lf_osc_enable,
   output reg [1:0] lf_divider_sel,
   output reg [3:0] lf_fine_tune,
   output reg lf_clk_out
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // last count of a divide-by-8/4/2/1 selection
   function [2:0] div_last;
      input [1:0] sel;
      begin
         case (sel)
            `IOC_DIV_SEL_8: div_last = `IOC_DIV_LAST_8;
            `IOC_DIV_SEL_4: div_last = `IOC_DIV_LAST_4;
            `IOC_DIV_SEL_2: div_last = `IOC_DIV_LAST_2;
            `IOC_DIV_SEL_1: div_last = `IOC_DIV_LAST_1;
            default: div_last = `IOC_DIV_LAST_8;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg hf_stable_m;
   reg hf_stable_s;
   reg lf_stable_m;
   reg lf_stable_s;
   reg lf_raw_m;
   reg lf_raw_s;
   reg lf_raw_d;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hf_stable_m <= 1'b1;
         hf_stable_s <= 1'b1;
         lf_stable_m <= 1'b0;
         lf_stable_s <= 1'b0;
         lf_raw_m <= 1'b0;
         lf_raw_s <= 1'b0;
         lf_raw_d <= 1'b0;
      end else begin
         hf_stable_m <= hf_osc_stable;
         hf_stable_s <= hf_stable_m;
         lf_stable_m <= lf_osc_stable;
         lf_stable_s <= lf_stable_m;
         lf_raw_m <= lf_osc_raw;
         lf_raw_s <= lf_raw_m;
         lf_raw_d <= lf_raw_s;
      end
   end

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   wire wr_hf = sfr_wr && (sfr_addr == `IOC_ADDR_HF_CTRL);
   wire wr_lf = sfr_wr && (sfr_addr == `IOC_ADDR_LF_CTRL);
   wire [1:0] wr_lf_div = sfr_wdata[`IOC_LF_DIV_HI:`IOC_LF_DIV_LO];
   wire lf_div_change = wr_lf && (wr_lf_div != lf_divider_sel);
   wire wake_event = port0_match | port1_match | timer3_overflow | usb_resume;

   reg hf_freq_ready;
   reg lf_ready_flag;

   // ---------------------------------------------------------------
   // high-frequency control
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hf_osc_enable <= `IOC_HF_EN_RST;
         hf_osc_suspend <= `IOC_HF_SUSP_RST;
         hf_divider_sel <= `IOC_HF_DIV_RST;
         hf_freq_ready <= `IOC_HF_RDY_RST;
         wake_pulse <= 1'b0;
      end else begin
         wake_pulse <= hf_osc_suspend & wake_event & ~wr_hf;
         if (wr_hf) begin
            hf_osc_enable <= sfr_wdata[`IOC_HF_EN_BIT];
            hf_divider_sel <= sfr_wdata[`IOC_HF_DIV_HI:`IOC_HF_DIV_LO];
            hf_osc_suspend <= sfr_wdata[`IOC_HF_SUSP_BIT];
         end else if (hf_osc_suspend && wake_event) begin
            hf_osc_suspend <= 1'b0;
         end
         hf_freq_ready <= hf_stable_s & hf_osc_enable & ~hf_osc_suspend;
      end
   end

   // ---------------------------------------------------------------
   // high-frequency divider: fixed /4 then /8, /4, /2 or /1
   // ---------------------------------------------------------------
   reg [1:0] hf_pre_cnt;
   reg [2:0] hf_div_cnt;
   wire hf_running = hf_osc_enable & ~hf_osc_suspend;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hf_pre_cnt <= 2'h0;
         hf_div_cnt <= 3'h0;
         hf_clk_en <= 1'b0;
      end else begin
         hf_clk_en <= 1'b0;
         if (!hf_running) begin
            hf_pre_cnt <= 2'h0;
            hf_div_cnt <= 3'h0;
         end else if (hf_pre_cnt == `IOC_HF_PRE_LAST) begin
            hf_pre_cnt <= 2'h0;
            if (hf_div_cnt >= div_last(hf_divider_sel)) begin
               hf_div_cnt <= 3'h0;
               hf_clk_en <= 1'b1;
            end else begin
               hf_div_cnt <= hf_div_cnt + 3'h1;
            end
         end else begin
            hf_pre_cnt <= hf_pre_cnt + 2'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // low-frequency control and ready flag
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lf_osc_enable <= `IOC_LF_EN_RST;
         lf_divider_sel <= `IOC_LF_DIV_RST;
         lf_fine_tune <= `IOC_LF_TUNE_RST;
         lf_ready_flag <= `IOC_LF_RDY_RST;
      end else begin
         if (wr_lf) begin
            lf_osc_enable <= sfr_wdata[`IOC_LF_EN_BIT];
            lf_divider_sel <= wr_lf_div;
            lf_fine_tune <= sfr_wdata[`IOC_LF_TUNE_HI:`IOC_LF_TUNE_LO];
         end
         // a divider change restarts stabilisation, so it beats the set
         if (lf_div_change) begin
            lf_ready_flag <= 1'b0;
         end else if (lf_osc_enable && lf_stable_s) begin
            lf_ready_flag <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // low-frequency divider: toggle after n input edges
   // ---------------------------------------------------------------
   reg [2:0] lf_edge_cnt;
   wire lf_edge = lf_raw_s ^ lf_raw_d;
   reg lf_out_d;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lf_edge_cnt <= 3'h0;
         lf_clk_out <= 1'b0;
         lf_out_d <= 1'b0;
      end else begin
         lf_out_d <= lf_clk_out;
         if (lf_div_change) begin
            lf_edge_cnt <= 3'h0;
         end else if (lf_osc_enable && lf_edge) begin
            if (lf_edge_cnt >= div_last(lf_divider_sel)) begin
               lf_edge_cnt <= 3'h0;
               lf_clk_out <= ~lf_clk_out;
            end else begin
               lf_edge_cnt <= lf_edge_cnt + 3'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // timer capture hook
   // ---------------------------------------------------------------
   wire lf_fall = lf_out_d & ~lf_clk_out;
   wire lf_rise = ~lf_out_d & lf_clk_out;

   ioc_lf_capture #(
      .WIDTH(TIMER_WIDTH)
   ) u_tmr2_capture (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .capture_mode(tmr2_lf_capture_mode),
      .edge_pulse(lf_fall),
      .timer_count(tmr2_timer_count),
      .timer_reload(tmr2_timer_reload),
      .reload_load(tmr2_reload_load)
   );

   ioc_lf_capture #(
      .WIDTH(TIMER_WIDTH)
   ) u_tmr3_capture (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .capture_mode(tmr3_lf_capture_mode),
      .edge_pulse(lf_rise),
      .timer_count(tmr3_timer_count),
      .timer_reload(tmr3_timer_reload),
      .reload_load(tmr3_reload_load)
   );

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   reg [7:0] next_rdata;

   always @* begin
      next_rdata = `IOC_READ_IDLE;
      case (sfr_addr)
         `IOC_ADDR_HF_CTRL: begin
            next_rdata[`IOC_HF_EN_BIT] = hf_osc_enable;
            next_rdata[`IOC_HF_RDY_BIT] = hf_freq_ready;
            next_rdata[`IOC_HF_SUSP_BIT] = hf_osc_suspend;
            next_rdata[`IOC_HF_DIV_HI:`IOC_HF_DIV_LO] = hf_divider_sel;
         end
         `IOC_ADDR_MULT: begin
            next_rdata = `IOC_MULT_VALUE;
         end
         `IOC_ADDR_LF_CTRL: begin
            next_rdata[`IOC_LF_EN_BIT] = lf_osc_enable;
            next_rdata[`IOC_LF_RDY_BIT] = lf_ready_flag;
            next_rdata[`IOC_LF_TUNE_HI:`IOC_LF_TUNE_LO] = lf_fine_tune;
            next_rdata[`IOC_LF_DIV_HI:`IOC_LF_DIV_LO] = lf_divider_sel;
         end
         default: begin
            next_rdata = `IOC_READ_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= `IOC_READ_IDLE;
      end else if (sfr_rd) begin
         sfr_rdata <= next_rdata;
      end
   end

endmodule // ioc_osc_ctrl

// ==== design/ioc_osc_defs.vh ====
// constants for the internal oscillator control block
// assumes an 8-bit special function register bus with byte addresses
`ifndef IOC_OSC_DEFS_VH
`define IOC_OSC_DEFS_VH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define IOC_ADDR_HF_CTRL 8'hb2
`define IOC_ADDR_MULT 8'hb9
`define IOC_ADDR_LF_CTRL 8'h86

// ---------------------------------------------------------------
// high-frequency control fields
// ---------------------------------------------------------------
`define IOC_HF_EN_BIT 7
`define IOC_HF_RDY_BIT 6
`define IOC_HF_SUSP_BIT 5
`define IOC_HF_DIV_HI 1
`define IOC_HF_DIV_LO 0
`define IOC_HF_EN_RST 1'h1
`define IOC_HF_RDY_RST 1'h1
`define IOC_HF_SUSP_RST 1'h0
`define IOC_HF_DIV_RST 2'h0

// ---------------------------------------------------------------
// multiplier compatibility value: enabled, initialized, locked,
// input select 00, unused bits zero
// ---------------------------------------------------------------
`define IOC_MULT_VALUE 8'he0

// ---------------------------------------------------------------
// low-frequency control fields
// ---------------------------------------------------------------
`define IOC_LF_EN_BIT 7
`define IOC_LF_RDY_BIT 6
`define IOC_LF_TUNE_HI 5
`define IOC_LF_TUNE_LO 2
`define IOC_LF_DIV_HI 1
`define IOC_LF_DIV_LO 0
`define IOC_LF_EN_RST 1'h0
`define IOC_LF_DIV_RST 2'h0
`define IOC_LF_TUNE_RST 4'h0
`define IOC_LF_RDY_RST 1'h0

// ---------------------------------------------------------------
// dividers
// ---------------------------------------------------------------
`define IOC_HF_PRE_LAST 2'h3
`define IOC_DIV_SEL_8 2'h0
`define IOC_DIV_SEL_4 2'h1
`define IOC_DIV_SEL_2 2'h2
`define IOC_DIV_SEL_1 2'h3
`define IOC_DIV_LAST_8 3'h7
`define IOC_DIV_LAST_4 3'h3
`define IOC_DIV_LAST_2 3'h1
`define IOC_DIV_LAST_1 3'h0
`define IOC_READ_IDLE 8'h00

`endif

// ==== design/ioc_lf_capture.v ====
// capture hook: copies a timer count into its reload pair on an edge
// assumes count, mode and edge pulse all come from the system clock
`timescale 1ns/100ps

module ioc_lf_capture #(
   parameter WIDTH = 16
) (
   // clock and reset
   input wire clk_sys,
   input wire arst_n,
   // capture control
   input wire capture_mode,
   input wire edge_pulse,
   input wire [WIDTH-1:0] timer_count,
   // reload pair
   output reg [WIDTH-1:0] timer_reload,
   output reg reload_load
);

   // ---------------------------------------------------------------
   // capture
   // ---------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         timer_reload <= {WIDTH{1'b0}};
         reload_load <= 1'b0;
      end else begin
         reload_load <= capture_mode & edge_pulse;
         if (capture_mode && edge_pulse) begin
            timer_reload <= timer_count;
         end
      end
   end

endmodule // ioc_lf_capture

// ==== testbench/ioc_osc_props.sv ====
// checker for the oscillator control block, bound onto its top module
// assumes one clock domain, clk_sys, with arst_n as reset
`timescale 1ns/100ps

module ioc_osc_props #(
   parameter TIMER_WIDTH = 16
) (
   input wire clk_sys,
   input wire arst_n,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   input wire [7:0] sfr_rdata,
   input wire port0_match,
   input wire port1_match,
   input wire timer3_overflow,
   input wire usb_resume,
   input wire tmr2_lf_capture_mode,
   input wire tmr3_lf_capture_mode,
   input wire [TIMER_WIDTH-1:0] tmr2_timer_count,
   input wire [TIMER_WIDTH-1:0] tmr3_timer_count,
   input wire [TIMER_WIDTH-1:0] tmr2_timer_reload,
   input wire tmr2_reload_load,
   input wire [TIMER_WIDTH-1:0] tmr3_timer_reload,
   input wire tmr3_reload_load,
   input wire hf_osc_enable,
   input wire hf_osc_suspend,
   input wire [1:0] hf_divider_sel,
   input wire hf_clk_en,
   input wire wake_pulse,
   input wire lf_clk_out,
   input wire [1:0] lf_divider_sel,
   input wire [3:0] lf_fine_tune
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   wire wk = port0_match | port1_match | timer3_overflow | usb_resume;
   wire hw = sfr_wr && sfr_addr == 8'hb2;
   property p_mult_ro;
      sfr_rd && sfr_addr == 8'hb9 |=> sfr_rdata == 8'he0;
   endproperty
   a_mult_ro: assert property (p_mult_ro) else $error("mult value wrong");
   property p_unused;
      sfr_rd && sfr_addr == 8'hb2 |=> sfr_rdata[4:2] == 3'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
   property p_hf_wr;
      hw |=> hf_osc_enable == $past(sfr_wdata[7]) && hf_divider_sel == $past(sfr_wdata[1:0]);
   endproperty
   a_hf_wr: assert property (p_hf_wr) else $error("hf write lost");
   property p_susp_wr;
      hw |=> hf_osc_suspend == $past(sfr_wdata[5]);
   endproperty
   a_susp_wr: assert property (p_susp_wr) else $error("suspend write lost");
   property p_wake;
      hf_osc_suspend && wk && !hw |=> !hf_osc_suspend && wake_pulse;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not taken");
   property p_wake_only;
      $rose(wake_pulse) |-> $past(hf_osc_suspend) && !hf_osc_suspend;
   endproperty
   a_wake_only: assert property (p_wake_only) else $error("stray wake");
   property p_susp_stop;
      hf_osc_suspend && $past(hf_osc_suspend) |-> !hf_clk_en;
   endproperty
   a_susp_stop: assert property (p_susp_stop) else $error("clock runs in suspend");
   property p_hf_min;
      hf_clk_en && hf_divider_sel == 2'h3 |=> (!hf_clk_en) [*3];
   endproperty
   a_hf_min: assert property (p_hf_min) else $error("hf enable too fast");
   property p_lf_wr;
      sfr_wr && sfr_addr == 8'h86 |=>
         lf_divider_sel == $past(sfr_wdata[1:0]) && lf_fine_tune == $past(sfr_wdata[5:2]);
   endproperty
   a_lf_wr: assert property (p_lf_wr) else $error("lf write lost");
   property p_cap2;
      tmr2_lf_capture_mode && $fell(lf_clk_out) |=>
         tmr2_reload_load && tmr2_timer_reload == $past(tmr2_timer_count);
   endproperty
   a_cap2: assert property (p_cap2) else $error("timer 2 capture wrong");
   property p_cap3;
      tmr3_lf_capture_mode && $rose(lf_clk_out) |=>
         tmr3_reload_load && tmr3_timer_reload == $past(tmr3_timer_count);
   endproperty
   a_cap3: assert property (p_cap3) else $error("timer 3 capture wrong");
   property p_cap2_only;
      tmr2_reload_load |->
         $past(tmr2_lf_capture_mode) && !$past(lf_clk_out) && $past(lf_clk_out, 2);
   endproperty
   a_cap2_only: assert property (p_cap2_only) else $error("stray timer 2 capture");
   property p_cap3_only;
      tmr3_reload_load |->
         $past(tmr3_lf_capture_mode) && $past(lf_clk_out) && !$past(lf_clk_out, 2);
   endproperty
   a_cap3_only: assert property (p_cap3_only) else $error("stray timer 3 capture");
   c_wake: cover property (hf_osc_suspend && wk);
   c_cap2: cover property (tmr2_reload_load);
   c_cap3: cover property (tmr3_reload_load);
endmodule // ioc_osc_props

bind ioc_osc_ctrl ioc_osc_props #(.TIMER_WIDTH(TIMER_WIDTH)) u_props (
   .clk_sys, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
   .port0_match, .port1_match, .timer3_overflow, .usb_resume,
   .tmr2_lf_capture_mode, .tmr3_lf_capture_mode, .tmr2_timer_count, .tmr3_timer_count,
   .tmr2_timer_reload, .tmr2_reload_load, .tmr3_timer_reload, .tmr3_reload_load,
   .hf_osc_enable, .hf_osc_suspend, .hf_divider_sel, .hf_clk_en, .wake_pulse,
   .lf_clk_out, .lf_divider_sel, .lf_fine_tune
);

// ==== testbench/tb.sv ====
// self-checking bench for the oscillator control block
// assumes the checker file binds itself onto the design
`timescale 1ns/100ps

module tb;
   reg clk_sys;
   reg arst_n = 1'b0;
   reg [7:0] sfr_addr = 8'h00;
   reg sfr_wr = 1'b0;
   reg sfr_rd = 1'b0;
   reg [7:0] sfr_wdata = 8'h00;
   reg hf_osc_stable = 1'b1;
   reg lf_osc_stable = 1'b0;
   reg lf_osc_raw = 1'b0;
   reg [3:0] wake = 4'h0;
   reg cap_on = 1'b0;
   reg lf_run = 1'b0;
   reg out_q = 1'b0;
   reg [15:0] cnt2 = 16'h0000;
   reg [15:0] cnt3 = 16'h0000;
   reg [7:0] d;
   reg [7:0] q;
   wire [7:0] sfr_rdata;
   wire [15:0] rl2, rl3;
   wire ld2, ld3, hf_en, hf_susp, hf_clk_en, wake_pulse, lf_en, lf_clk_out;
   wire [1:0] hf_div, lf_div;
   wire [3:0] lf_tune;
   integer error_cnt = 0, num_checks = 0, cycles = 0, raw_cnt = 0, out_cnt = 0;
   integer ph = 0, loads = 0, i, k, n;

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   ioc_osc_ctrl uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .hf_osc_stable(hf_osc_stable), .lf_osc_stable(lf_osc_stable), .lf_osc_raw(lf_osc_raw),
      .port0_match(wake[0]), .port1_match(wake[1]), .timer3_overflow(wake[2]),
      .usb_resume(wake[3]), .tmr2_lf_capture_mode(cap_on), .tmr3_lf_capture_mode(cap_on),
      .tmr2_timer_count(cnt2), .tmr3_timer_count(cnt3), .tmr2_timer_reload(rl2),
      .tmr2_reload_load(ld2), .tmr3_timer_reload(rl3), .tmr3_reload_load(ld3),
      .hf_osc_enable(hf_en), .hf_osc_suspend(hf_susp), .hf_divider_sel(hf_div),
      .hf_clk_en(hf_clk_en), .wake_pulse(wake_pulse), .lf_osc_enable(lf_en),
      .lf_divider_sel(lf_div), .lf_fine_tune(lf_tune), .lf_clk_out(lf_clk_out)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [7:0] exp_b2(input [7:0] v);
      exp_b2 = {v[7], v[7], 4'h0, v[1:0]};
   endfunction

   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] v);
      begin
         @(negedge clk_sys);
         sfr_addr = a;
         sfr_wdata = v;
         sfr_wr = 1'b1;
         @(negedge clk_sys);
         sfr_wr = 1'b0;
      end
   endtask

   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         @(negedge clk_sys);
         sfr_addr = a;
         sfr_rd = 1'b1;
         @(negedge clk_sys);
         sfr_rd = 1'b0;
         chk(sfr_rdata, e);
      end
   endtask

   task gap(output integer m);
      begin
         m = 1;
         @(negedge clk_sys);
         while (hf_clk_en !== 1'b1 && m < 200) begin
            @(negedge clk_sys);
            m = m + 1;
         end
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d errors %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   // raw lf waveform, timer counts, edge counters and timeout
   always @(negedge clk_sys) begin
      cycles = cycles + 1;
      {cnt2, cnt3} <= $urandom;
      if (lf_run) begin
         ph = ph + 1;
         if (ph == 10) begin
            ph = 0;
            lf_osc_raw <= ~lf_osc_raw;
            raw_cnt = raw_cnt + 1;
         end
      end
      if (lf_clk_out !== out_q)
         out_cnt = out_cnt + 1;
      out_q = lf_clk_out;
      if (ld2 === 1'b1 || ld3 === 1'b1)
         loads = loads + 1;
      if (cycles > 20000) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t timeout", $time);
         end_of_test;
      end
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      k = $urandom(32'hdfcc);
      repeat (4) @(negedge clk_sys);
      arst_n = 1'b1;
      chk({6'h00, hf_en, lf_en}, 8'h02);
      rd_chk(8'hb2, 8'hc0);
      rd_chk(8'hb9, 8'he0);
      rd_chk(8'h86, 8'h00);
      $display("test reset done");
      for (i = 0; i < 24; i = i + 1) begin
         d = $urandom & 8'hdf;
         if (i == 0)
            d = 8'h1c;
         wr(8'hb2, d);
         wr(8'hb9, ~d);
         repeat (4) @(negedge clk_sys);
         rd_chk(8'hb2, exp_b2(d));
         rd_chk(8'hb9, 8'he0);
      end
      wr(8'hb2, 8'h80);
      hf_osc_stable = 1'b0;
      repeat (5) @(negedge clk_sys);
      rd_chk(8'hb2, 8'h80);
      hf_osc_stable = 1'b1;
      $display("test registers done");
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'hb2, {6'h20, k[1:0]});
         gap(n);
         gap(n);
         chk(n, 32 >> k);
      end
      $display("test hf divider done");
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'hb2, 8'ha3);
         repeat (6) @(negedge clk_sys);
         chk({7'h00, hf_susp}, 8'h01);
         wake = 4'h1 << k;
         @(negedge clk_sys);
         wake = 4'h0;
         chk({7'h00, hf_susp}, 8'h00);
         repeat (4) @(negedge clk_sys);
         rd_chk(8'hb2, 8'hc3);
      end
      wake = 4'h1;
      @(negedge clk_sys);
      wake = 4'h0;
      chk({7'h00, wake_pulse}, 8'h00);
      $display("test suspend done");
      lf_osc_stable = 1'b1;
      cap_on = 1'b1;
      lf_run = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
         q = $urandom;
         d = {2'b10, q[3:0], k[1:0]};
         wr(8'h86, d);
         repeat (6) @(negedge clk_sys);
         rd_chk(8'h86, d | 8'h40);
         chk({7'h00, lf_en}, 8'h01);
         @(posedge clk_sys);
         raw_cnt = 0;
         out_cnt = 0;
         repeat (650) @(negedge clk_sys);
         n = 8 >> k;
         num_checks = num_checks + 1;
         if (out_cnt * n + n < raw_cnt || raw_cnt + n < out_cnt * n) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t lf divide %0d raw %0d out %0d", $time, n, raw_cnt, out_cnt);
         end
      end
      chk((loads > 0) ? 8'h01 : 8'h00, 8'h01);
      lf_osc_stable = 1'b0;
      repeat (6) @(negedge clk_sys);
      rd_chk(8'h86, d | 8'h40);
      wr(8'h86, d);
      rd_chk(8'h86, d | 8'h40);
      wr(8'h86, d ^ 8'h01);
      repeat (2) @(negedge clk_sys);
      rd_chk(8'h86, (d ^ 8'h01) & 8'hbf);
      $display("test lf done");
      end_of_test;
   end
endmodule // tb
